// >>> aer_regs_pkg.sv
// Register offsets, field positions and reset values for the error registers
package aer_regs_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam logic [11:0] SEV_OFFSET    = 12'h10c;
    localparam logic [11:0] CSTAT_OFFSET  = 12'h110;
    // Severity register fields
    localparam int SEV_UNSUP_BIT    = 20;
    localparam int SEV_ECRC_BIT     = 19;
    localparam int SEV_MALFORM_BIT  = 18;
    localparam int SEV_OVERFLOW_BIT = 17;
    localparam int SEV_UNEXP_BIT    = 16;
    localparam int SEV_ABORT_BIT    = 15;
    localparam int SEV_CPL_TO_BIT   = 14;
    localparam int SEV_FCP_BIT      = 13;
    localparam int SEV_POISON_BIT   = 12;
    localparam int SEV_SD_BIT   = 5;
    localparam int SEV_DLP_BIT  = 4;
    localparam int SEV_RSV0_BIT = 0;
    localparam logic [31:0] SEV_RESET     = 32'h0006_2030;
    localparam logic [31:0] SEV_WMASK     = 32'h001f_f030;
    // Correctable status fields
    localparam int CS_ANF_BIT   = 13;
    localparam int CS_RTO_BIT   = 12;
    localparam int CS_RRO_BIT   = 8;
    localparam int CS_BDL_BIT   = 7;
    localparam int CS_BTL_BIT   = 6;
    localparam int CS_RX_ERR_BIT = 0;
    localparam logic [31:0] CSTAT_RESET   = 32'h0000_0000;
    localparam logic [31:0] CSTAT_MASK    = 32'h0000_31c1;
endpackage : aer_regs_pkg

// >>> pcie_aer_severity_corr_status.sv
// Error severity and correctable status registers
`timescale 1ns/1ns
// How it works
// - Bit 20 of severity holds the unsupported-request severity, sticky, reset 0.
// - Bit 13 of severity holds the flow-control protocol severity, reset 1.
// - Bit 5 of severity holds the surprise-down severity, reset 1.
// - Bit 4 of severity holds the link protocol severity, reset 1.
// - Severity bit 0 is read-only and always reads 0.
// - Status bit 13 flags advisory non-fatal errors, cleared by writing 1.
// - Status bit 12 is set on replay timer expiry, cleared by writing 1.
// - Status bit 7 is set when a link packet's CRC mismatches.
// - Status bit 6 is set when the physical layer flags a packet error.
// - Bit 6 is set when an EDB packet's CRC is not the inverse of calc.
// - Bit 6 is set when a normal packet's CRC mismatches.
module pcie_aer_severity_corr_status
#(
    parameter int CRC_W = 32
) (
    // Clock and resets
    input  wire logic                            CLK_I,
    input  wire logic                            RST_N_I,
    input  wire logic                            POWER_ON_RST_N_I,
    // Configuration access
    input  wire logic                            CFG_WR_I,
    input  wire logic                            CFG_RD_I,
    input  wire logic [aer_regs_pkg::ADDR_W-1:0] CFG_ADDR_I,
    input  wire logic [3:0]                      CFG_BE_I,
    input  wire logic [aer_regs_pkg::DATA_W-1:0] CFG_WDATA_I,
    output logic      [aer_regs_pkg::DATA_W-1:0] CFG_RDATA_O,
    output logic                                 CFG_RVALID_O,
    // Error events
    input  wire logic                            ADVISORY_NONFATAL_I,
    input  wire logic                            REPLAY_TIMER_EXPIRED_I,
    input  wire logic                            REPLAY_COUNT_ROLLOVER_I,
    input  wire logic                            RECEIVER_ERROR_I,
    input  wire logic                            DL_VALID_I,
    input  wire logic [CRC_W-1:0]                DL_CALC_CRC_I,
    input  wire logic [CRC_W-1:0]                DL_RX_CRC_I,
    input  wire logic                            TL_VALID_I,
    input  wire logic                            TL_PHY_ERR_I,
    input  wire logic                            TL_EDB_I,
    input  wire logic [CRC_W-1:0]                TL_CALC_CRC_I,
    input  wire logic [CRC_W-1:0]                TL_RX_CRC_I,
    // Severity and status levels
    output logic      [aer_regs_pkg::DATA_W-1:0] SEVERITY_O,
    output logic      [aer_regs_pkg::DATA_W-1:0] CORR_STATUS_O
);
    import aer_regs_pkg::*;

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    typedef struct packed {
        logic [31:0] sev;
        logic [31:0] cstat;
        logic [31:0] rdata;
        logic        rvalid;
    } state_t;

    state_t      s_q;
    state_t      s_d;
    logic        bad_dl;
    logic        bad_tl;
    logic [31:0] wmask;
    logic [31:0] events;

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    //--------------------------------------------------------------
    // Packet checks
    //--------------------------------------------------------------
    pkt_crc_check #(
        .CRC_W (CRC_W)
    ) u_crc (
        .dl_valid_i    (DL_VALID_I),
        .dl_calc_crc_i (DL_CALC_CRC_I),
        .dl_rx_crc_i   (DL_RX_CRC_I),
        .tl_valid_i    (TL_VALID_I),
        .tl_phy_err_i  (TL_PHY_ERR_I),
        .tl_edb_i      (TL_EDB_I),
        .tl_calc_crc_i (TL_CALC_CRC_I),
        .tl_rx_crc_i   (TL_RX_CRC_I),
        .bad_dl_o      (bad_dl),
        .bad_tl_o      (bad_tl)
    );

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        wmask = be_mask(CFG_BE_I) & CFG_WDATA_I;
        events = 32'h0000_0000;
        events[CS_ANF_BIT] = ADVISORY_NONFATAL_I;
        events[CS_RTO_BIT] = REPLAY_TIMER_EXPIRED_I;
        events[CS_RRO_BIT] = REPLAY_COUNT_ROLLOVER_I;
        events[CS_BDL_BIT] = bad_dl;
        events[CS_BTL_BIT] = bad_tl;
        events[CS_RX_ERR_BIT] = RECEIVER_ERROR_I;
        if (CFG_WR_I && CFG_ADDR_I == SEV_OFFSET)
        begin
            // Only writable bits change; bit 0 and reserved stay 0
            s_d.sev = (s_q.sev & ~(be_mask(CFG_BE_I) & SEV_WMASK))
                    | (CFG_WDATA_I & be_mask(CFG_BE_I) & SEV_WMASK);
        end
        // Set wins over write-1-to-clear
        if (CFG_WR_I && CFG_ADDR_I == CSTAT_OFFSET)
            s_d.cstat = s_q.cstat & ~(wmask & CSTAT_MASK);
        s_d.cstat = s_d.cstat | (events & CSTAT_MASK);
        s_d.rvalid = CFG_RD_I;
        s_d.rdata = 32'h0000_0000;
        if (CFG_RD_I)
        begin
            case (CFG_ADDR_I)
                SEV_OFFSET:   s_d.rdata = s_q.sev & SEV_WMASK;
                CSTAT_OFFSET: s_d.rdata = s_q.cstat & CSTAT_MASK;
                default:      s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (!POWER_ON_RST_N_I)
        begin
            s_q.sev    <= SEV_RESET;
            s_q.cstat  <= CSTAT_RESET;
            s_q.rdata  <= 32'h0000_0000;
            s_q.rvalid <= 1'b0;
        end
        else if (!RST_N_I)
        begin
            // Hot or warm reset leaves sticky contents alone
            s_q.sev    <= s_q.sev;
            s_q.cstat  <= s_q.cstat;
            s_q.rdata  <= 32'h0000_0000;
            s_q.rvalid <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign CFG_RDATA_O   = s_q.rdata;
    assign CFG_RVALID_O  = s_q.rvalid;
    assign SEVERITY_O    = s_q.sev;
    assign CORR_STATUS_O = s_q.cstat;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    sev_bit0_zero_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I)
        !SEVERITY_O[SEV_RSV0_BIT] && (SEVERITY_O & ~SEV_WMASK) == 32'h0)
        else $error("Severity reserved bit set");
    cstat_rsv_zero_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I)
        (CORR_STATUS_O & ~CSTAT_MASK) == 32'h0)
        else $error("Status reserved bit set");
    sev_unsup_write_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I || !RST_N_I)
        CFG_WR_I && CFG_ADDR_I == SEV_OFFSET && CFG_BE_I[2]
        |=> SEVERITY_O[SEV_UNSUP_BIT] == $past(CFG_WDATA_I[SEV_UNSUP_BIT]))
        else $error("Severity bit 20 not written");
    por_reset_val_a: assert property (@(posedge CLK_I)
        !POWER_ON_RST_N_I |=> SEVERITY_O == SEV_RESET &&
        CORR_STATUS_O == CSTAT_RESET)
        else $error("Power-on reset value wrong");
    warm_keep_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I)
        !RST_N_I |=> $stable(SEVERITY_O) && $stable(CORR_STATUS_O))
        else $error("Sticky bits lost in warm reset");
    rto_set_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I || !RST_N_I)
        REPLAY_TIMER_EXPIRED_I |=> CORR_STATUS_O[CS_RTO_BIT])
        else $error("Replay timeout not flagged");
    bdl_set_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I || !RST_N_I)
        DL_VALID_I && DL_CALC_CRC_I != DL_RX_CRC_I
        |=> CORR_STATUS_O[CS_BDL_BIT])
        else $error("Bad link packet not flagged");
    btl_edb_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I || !RST_N_I)
        TL_VALID_I && TL_EDB_I && TL_RX_CRC_I != ~TL_CALC_CRC_I
        |=> CORR_STATUS_O[CS_BTL_BIT])
        else $error("Bad EDB packet not flagged");
    anf_clear_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I || !RST_N_I)
        CFG_WR_I && CFG_ADDR_I == CSTAT_OFFSET && CFG_BE_I[1] &&
        CFG_WDATA_I[CS_ANF_BIT] && !ADVISORY_NONFATAL_I
        |=> !CORR_STATUS_O[CS_ANF_BIT])
        else $error("Advisory flag not cleared");
    btl_phy_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I || !RST_N_I)
        TL_VALID_I && TL_PHY_ERR_I |=> CORR_STATUS_O[CS_BTL_BIT])
        else $error("Physical layer packet error not flagged");
    btl_crc_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I || !RST_N_I)
        TL_VALID_I && !TL_PHY_ERR_I && !TL_EDB_I &&
        TL_RX_CRC_I != TL_CALC_CRC_I |=> CORR_STATUS_O[CS_BTL_BIT])
        else $error("Bad transaction packet not flagged");
    anf_set_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I || !RST_N_I)
        ADVISORY_NONFATAL_I |=> CORR_STATUS_O[CS_ANF_BIT])
        else $error("Advisory error not flagged");
    rto_sticky_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I || !RST_N_I)
        CORR_STATUS_O[CS_RTO_BIT] &&
        !(CFG_WR_I && CFG_ADDR_I == CSTAT_OFFSET)
        |=> CORR_STATUS_O[CS_RTO_BIT])
        else $error("Replay timeout flag lost");
    rd_pulse_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I || !RST_N_I)
        CFG_RD_I |=> CFG_RVALID_O)
        else $error("Read answer missing");
    rd_idle_zero_a: assert property (@(posedge CLK_I)
        disable iff (!POWER_ON_RST_N_I)
        !CFG_RD_I |=> !CFG_RVALID_O && CFG_RDATA_O == 32'h0000_0000)
        else $error("Read data not zero when idle");
endmodule : pcie_aer_severity_corr_status

// >>> pcie_aer_severity_corr_status_test.sv
// Self-checking bench for the severity and correctable status registers
`timescale 1ns/1ns
module pcie_aer_severity_corr_status_test;
    import aer_regs_pkg::*;
    typedef struct {
        logic [11:0] a;
        logic [3:0]  b;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;
    localparam logic [31:0] CRC = 32'h1234abcd;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        por_n = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [3:0]  be = 4'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic [3:0]  evt = 4'h0;
    logic        dlv = 1'b0;
    logic        tlv = 1'b0;
    logic        phy = 1'b0;
    logic        edb = 1'b0;
    logic [31:0] rx = 32'h0000_0000;
    logic [31:0] rdata;
    logic        rvalid;
    logic [31:0] sev;
    logic [31:0] cst;
    logic [31:0] q;
    int          errors = 0;
    int          compares = 0;
    row_t        rows[6];
    // ----------------------------------------
    // Design and clock
    // ----------------------------------------
    pcie_aer_severity_corr_status dut (
        .CLK_I(clk), .RST_N_I(rst_n), .POWER_ON_RST_N_I(por_n),
        .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_ADDR_I(addr), .CFG_BE_I(be),
        .CFG_WDATA_I(wd), .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid),
        .ADVISORY_NONFATAL_I(evt[3]), .REPLAY_TIMER_EXPIRED_I(evt[2]),
        .REPLAY_COUNT_ROLLOVER_I(evt[1]), .RECEIVER_ERROR_I(evt[0]),
        .DL_VALID_I(dlv), .DL_CALC_CRC_I(CRC), .DL_RX_CRC_I(rx),
        .TL_VALID_I(tlv), .TL_PHY_ERR_I(phy), .TL_EDB_I(edb),
        .TL_CALC_CRC_I(CRC), .TL_RX_CRC_I(rx),
        .SEVERITY_O(sev), .CORR_STATUS_O(cst));
    always #5 clk = ~clk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc();
        @(posedge clk);
        #1;
    endtask : cyc
    task automatic cfg_wr(input logic [11:0] a, input logic [3:0] b,
                          input logic [31:0] d);
        cyc();
        wr = 1'b1;
        addr = a;
        be = b;
        wd = d;
        cyc();
        wr = 1'b0;
    endtask : cfg_wr
    task automatic cfg_rd(input logic [11:0] a);
        rd = 1'b1;
        addr = a;
        cyc();
        rd = 1'b0;
        q = rdata;
        chk({31'h0, rvalid}, 32'h0000_0001);
    endtask : cfg_rd
    task automatic pkt(input logic l, p, e, input logic [31:0] r, x);
        dlv = l;
        tlv = !l;
        phy = p;
        edb = e;
        rx = r;
        cyc();
        dlv = 1'b0;
        tlv = 1'b0;
        chk(cst, x);
        cfg_wr(CSTAT_OFFSET, 4'hf, 32'hffff_ffff);
    endtask : pkt
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        end_sim();
    end
    initial
    begin
        rows[0] = '{SEV_OFFSET, 4'h0, 32'hfffeffff, 32'h00062030};
        rows[1] = '{SEV_OFFSET, 4'hf, 32'hfffeffff, 32'h001ef030};
        rows[2] = '{SEV_OFFSET, 4'h1, 32'h00000000, 32'h001ef000};
        rows[3] = '{SEV_OFFSET, 4'hf, 32'h00000000, 32'h00000000};
        rows[4] = '{12'h114, 4'hf, 32'hffffffff, 32'h00000000};
        rows[5] = '{CSTAT_OFFSET, 4'hf, 32'hffffffff, 32'h00000000};
        repeat (10) cyc();
        rst_n = 1'b1;
        por_n = 1'b1;
        cfg_rd(SEV_OFFSET);
        chk(q, 32'h0006_2030);
        cyc();
        chk({31'h0, rvalid}, 32'h0000_0000);
        chk(rdata, 32'h0000_0000);
        foreach (rows[i])
        begin
            cfg_wr(rows[i].a, rows[i].b, rows[i].d);
            cfg_rd(rows[i].a);
            chk(q, rows[i].e);
        end
        cfg_wr(SEV_OFFSET, 4'hf, 32'h0010_2010);
        evt = 4'hf;
        cyc();
        evt = 4'h0;
        rst_n = 1'b0;
        cyc();
        rst_n = 1'b1;
        chk(sev, 32'h0010_2010);
        cfg_rd(CSTAT_OFFSET);
        chk(q, 32'h0000_3101);
        cfg_wr(CSTAT_OFFSET, 4'hf, 32'h0000_2000);
        chk(cst, 32'h0000_1101);
        cfg_wr(CSTAT_OFFSET, 4'hf, 32'h0000_0000);
        chk(cst, 32'h0000_1101);
        evt = 4'h4;
        cfg_wr(CSTAT_OFFSET, 4'hf, 32'h0000_1000);
        evt = 4'h0;
        chk(cst, 32'h0000_1101);
        cfg_wr(CSTAT_OFFSET, 4'hf, 32'h0000_1000);
        chk(cst, 32'h0000_0101);
        cfg_wr(CSTAT_OFFSET, 4'hf, 32'hffff_ffff);
        chk(cst, 32'h0000_0000);
        pkt(1'b1, 1'b0, 1'b0, CRC, 32'h0000_0000);
        pkt(1'b1, 1'b0, 1'b0, CRC ^ 32'h1, 32'h0000_0080);
        pkt(1'b0, 1'b1, 1'b0, CRC, 32'h0000_0040);
        pkt(1'b0, 1'b0, 1'b1, ~CRC, 32'h0000_0000);
        pkt(1'b0, 1'b0, 1'b1, CRC, 32'h0000_0040);
        pkt(1'b0, 1'b0, 1'b0, CRC, 32'h0000_0000);
        pkt(1'b0, 1'b0, 1'b0, CRC ^ 32'h100, 32'h0000_0040);
        evt = 4'h8;
        cyc();
        evt = 4'h0;
        por_n = 1'b0;
        cyc();
        por_n = 1'b1;
        chk(sev, 32'h00062030);
        chk(cst, 32'h00000000);
        end_sim();
    end
endmodule : pcie_aer_severity_corr_status_test

// >>> pkt_crc_check.sv
// Received packet CRC checks feeding the bad-packet flags
`timescale 1ns/1ns
module pkt_crc_check #(
    parameter int CRC_W = 32
) (
    // Link packet
    input  wire logic             dl_valid_i,
    input  wire logic [CRC_W-1:0] dl_calc_crc_i,
    input  wire logic [CRC_W-1:0] dl_rx_crc_i,
    // Transaction packet
    input  wire logic             tl_valid_i,
    input  wire logic             tl_phy_err_i,
    input  wire logic             tl_edb_i,
    input  wire logic [CRC_W-1:0] tl_calc_crc_i,
    input  wire logic [CRC_W-1:0] tl_rx_crc_i,
    // Event pulses
    output logic                  bad_dl_o,
    output logic                  bad_tl_o
);
    always_comb
    begin
        bad_dl_o = dl_valid_i && (dl_calc_crc_i != dl_rx_crc_i);
        bad_tl_o = 1'b0;
        if (tl_valid_i)
        begin
            if (tl_phy_err_i)
                bad_tl_o = 1'b1;
            else if (tl_edb_i)
                bad_tl_o = (tl_rx_crc_i != ~tl_calc_crc_i);
            else
                bad_tl_o = (tl_rx_crc_i != tl_calc_crc_i);
        end
    end
endmodule : pkt_crc_check
